// >>> shared/wrap_pkg.sv
package wrap_pkg;

    // ------------------------------------------------
    // object indices
    // ------------------------------------------------
    localparam logic [15:0] IDX_WRAP_EN = 16'h41c7;
    localparam logic [15:0] IDX_WRAP_RANGE = 16'h41c9;
    localparam logic [15:0] IDX_OFFS_RATIO = 16'h41cb;
    localparam logic [15:0] IDX_OFFS_VALUE = 16'h41cc;
    localparam logic [15:0] IDX_DIV_COUNT = 16'h41cd;
    localparam logic [15:0] IDX_GEAR = 16'h6091;
    localparam logic [7:0] SUB_GEAR_A = 8'h01;
    localparam logic [7:0] SUB_GEAR_B = 8'h02;
    localparam logic [7:0] SUB_NONE = 8'h00;
    localparam logic [15:0] IDX_SAVE_ALL = 16'h40c9;
    localparam logic [15:0] IDX_CONFIG = 16'h40c6;
    localparam logic [15:0] IDX_STATUS = 16'h40f0;

    // ------------------------------------------------
    // non-volatile memory word layout
    // ------------------------------------------------
    localparam int NV_PARAMS = 7;
    localparam int NV_DEPTH = 8;
    localparam logic [2:0] W_EN = 3'h0;
    localparam logic [2:0] W_RANGE = 3'h1;
    localparam logic [2:0] W_RATIO = 3'h2;
    localparam logic [2:0] W_OFFS = 3'h3;
    localparam logic [2:0] W_DIV = 3'h4;
    localparam logic [2:0] W_GEAR_A = 3'h5;
    localparam logic [2:0] W_GEAR_B = 3'h6;
    localparam logic [2:0] W_MARK = 3'h7;
    // value is arbitrary, marks a written image
    localparam logic [15:0] NV_SIG = 16'h5a3c;

    // ------------------------------------------------
    // defaults and limits
    // ------------------------------------------------
    localparam logic [31:0] DEF_EN = 32'h1;
    localparam logic [31:0] DEF_RANGE = 32'ha;
    localparam logic [31:0] DEF_RATIO = 32'h1388;
    localparam logic [31:0] DEF_OFFS = 32'h0;
    localparam logic [31:0] DEF_DIV = 32'h1;
    localparam logic [31:0] DEF_GEAR = 32'h1;
    localparam logic [31:0] RATIO_MAX = 32'h2710;
    localparam logic [63:0] RATIO_FULL = 64'h2710;
    localparam logic [31:0] DIV_MAX = 32'h1fffffff;
    localparam logic [31:0] RANGE_MAX = 32'h4650;
    localparam logic [31:0] TURNS_LARGE = 32'h4650;
    localparam logic [31:0] TURNS_SMALL = 32'h2328;
    localparam logic [63:0] STEPS_PER_REV = 64'h2710;
    localparam logic [63:0] RANGE_UNITS_PER_REV = 64'ha;
    localparam logic [63:0] STEP_FACTOR = STEPS_PER_REV / RANGE_UNITS_PER_REV;
    localparam int OFFS_SIGN_LSB = 29;

    // ------------------------------------------------
    // commands, alarms, timing
    // ------------------------------------------------
    localparam logic [1:0] CMD_IDLE = 2'h0;
    localparam logic [1:0] CMD_RUN = 2'h1;
    localparam logic [1:0] CMD_AUTO = 2'h2;
    localparam logic [7:0] ALM_NONE = 8'h00;
    localparam logic [7:0] ALM_MEM = 8'h41;
    localparam logic [7:0] ALM_WRAP = 8'h2f;
    localparam longint NV_HOLD_S = 5;
    localparam longint CLK_HZ = 250000000;
    localparam longint NV_HOLD_CYCLES = NV_HOLD_S * CLK_HZ;

    function automatic logic [31:0] default_word(input int i);
        case (i)
            0: default_word = DEF_EN;
            1: default_word = DEF_RANGE;
            2: default_word = DEF_RATIO;
            3: default_word = DEF_OFFS;
            4: default_word = DEF_DIV;
            default: default_word = DEF_GEAR;
        endcase
    endfunction

endpackage

// >>> rtl/maint_cmd_cell.sv
`timescale 1ns/1ps
module maint_cmd_cell
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // command data write
    input wire logic wr_in,
    input wire logic [31:0] data_in,
    // state and execution
    output logic [1:0] data_out,
    output logic exec_out
);

    logic [1:0] data_reg;
    logic [1:0] data_next;
    logic exec_reg;
    logic exec_next;
    wire is_idle = (data_in == {30'h0, wrap_pkg::CMD_IDLE});
    wire is_run = (data_in == {30'h0, wrap_pkg::CMD_RUN});
    wire is_auto = (data_in == {30'h0, wrap_pkg::CMD_AUTO});

    // ------------------------------------------------
    // edge and auto-restore execution
    // ------------------------------------------------
    assign exec_next = wr_in & (is_auto | (is_run & (data_reg == wrap_pkg::CMD_IDLE)));
    assign data_next = !wr_in ? data_reg :
                       is_idle ? wrap_pkg::CMD_IDLE :
                       (is_run | is_auto) ? wrap_pkg::CMD_RUN : data_reg;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            data_reg <= wrap_pkg::CMD_IDLE;
            exec_reg <= 1'b0;
        end
        else
        begin
            data_reg <= data_next;
            exec_reg <= exec_next;
        end
    end

    assign data_out = data_reg;
    assign exec_out = exec_reg;

endmodule

// >>> rtl/wrap_coord_top.sv
`timescale 1ns/1ps
module wrap_coord_top
#(
    parameter logic [31:0] NV_HOLD_CYCLES = 32'(wrap_pkg::NV_HOLD_CYCLES)
)
(
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    // object access from the fieldbus
    input wire logic OBJ_WR_IN,
    input wire logic OBJ_RD_IN,
    input wire logic [15:0] OBJ_INDEX_IN,
    input wire logic [7:0] OBJ_SUB_IN,
    input wire logic [31:0] OBJ_WDATA_IN,
    output logic [31:0] OBJ_RDATA_OUT,
    output logic OBJ_ACK_OUT,
    output logic OBJ_ERR_OUT,
    // motion and pins
    input wire logic STEP_IN,
    input wire logic DIR_IN,
    input wire logic SMALL_FRAME_IN,
    input wire logic POWER_FAIL_IN,
    // coordinate and status
    output logic [31:0] WRAP_POS_OUT,
    output logic WRAP_DIVISION_MARKER_OUT,
    output logic WRAP_ERR_INFO_OUT,
    output logic ALARM_OUT,
    output logic [7:0] ALARM_CODE_OUT,
    output logic NV_BUSY_OUT
);

    typedef enum logic [2:0] {ST_LOAD, ST_APPLY, ST_IDLE, ST_MARK, ST_SAVE, ST_HOLD,
        ST_CLEAN, ST_HALT} state_t;

    // ------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------
    logic [2:0] frame_sync_reg;
    logic [2:0] pfail_sync_reg;
    logic small_frame_reg;
    logic pfail_reg;

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RESET_IN)
        begin
            frame_sync_reg <= 3'h0;
            pfail_sync_reg <= 3'h0;
            small_frame_reg <= 1'b0;
            pfail_reg <= 1'b0;
        end
        else
        begin
            frame_sync_reg <= {frame_sync_reg[1:0], SMALL_FRAME_IN};
            pfail_sync_reg <= {pfail_sync_reg[1:0], POWER_FAIL_IN};
            if (frame_sync_reg[1] == frame_sync_reg[2])
                small_frame_reg <= frame_sync_reg[2];
            if (pfail_sync_reg[1] == pfail_sync_reg[2])
                pfail_reg <= pfail_sync_reg[2];
        end
    end

    // ------------------------------------------------
    // object decode
    // ------------------------------------------------
    state_t state_reg;
    state_t state_next;
    logic [2:0] idx_reg;
    logic [31:0] hold_reg;
    logic [31:0] work_reg [0:wrap_pkg::NV_PARAMS-1];
    logic [31:0] nv_mem [0:wrap_pkg::NV_DEPTH-1] = '{default: 32'h0};
    logic [1:0] save_data;
    logic [1:0] cfg_data;
    logic save_exec;
    logic cfg_exec;
    logic [31:0] rdata_next;

    wire sub0 = (OBJ_SUB_IN == wrap_pkg::SUB_NONE);
    wire hit_en = (OBJ_INDEX_IN == wrap_pkg::IDX_WRAP_EN) & sub0;
    wire hit_range = (OBJ_INDEX_IN == wrap_pkg::IDX_WRAP_RANGE) & sub0;
    wire hit_ratio = (OBJ_INDEX_IN == wrap_pkg::IDX_OFFS_RATIO) & sub0;
    wire hit_offs = (OBJ_INDEX_IN == wrap_pkg::IDX_OFFS_VALUE) & sub0;
    wire hit_div = (OBJ_INDEX_IN == wrap_pkg::IDX_DIV_COUNT) & sub0;
    wire hit_ga = (OBJ_INDEX_IN == wrap_pkg::IDX_GEAR) & (OBJ_SUB_IN == wrap_pkg::SUB_GEAR_A);
    wire hit_gb = (OBJ_INDEX_IN == wrap_pkg::IDX_GEAR) & (OBJ_SUB_IN == wrap_pkg::SUB_GEAR_B);
    wire hit_save = (OBJ_INDEX_IN == wrap_pkg::IDX_SAVE_ALL) & sub0;
    wire hit_cfg = (OBJ_INDEX_IN == wrap_pkg::IDX_CONFIG) & sub0;
    wire hit_stat = (OBJ_INDEX_IN == wrap_pkg::IDX_STATUS) & sub0;
    wire hit_param = hit_en | hit_range | hit_ratio | hit_offs | hit_div | hit_ga | hit_gb;
    wire [2:0] obj_word = hit_en ? wrap_pkg::W_EN : hit_range ? wrap_pkg::W_RANGE :
                          hit_ratio ? wrap_pkg::W_RATIO : hit_offs ? wrap_pkg::W_OFFS :
                          hit_div ? wrap_pkg::W_DIV : hit_ga ? wrap_pkg::W_GEAR_A :
                          wrap_pkg::W_GEAR_B;
    wire [2:0] offs_top = OBJ_WDATA_IN[31:wrap_pkg::OFFS_SIGN_LSB];
    wire val_ok = hit_en ? (OBJ_WDATA_IN <= wrap_pkg::DEF_EN) :
                  hit_range ? (OBJ_WDATA_IN != 32'h0) & (OBJ_WDATA_IN <= wrap_pkg::RANGE_MAX) :
                  hit_ratio ? (OBJ_WDATA_IN <= wrap_pkg::RATIO_MAX) :
                  hit_offs ? ((offs_top == 3'h0) | (offs_top == 3'h7)) :
                  hit_div ? (OBJ_WDATA_IN != 32'h0) & (OBJ_WDATA_IN <= wrap_pkg::DIV_MAX) :
                  (OBJ_WDATA_IN != 32'h0);
    wire cmd_ok = (OBJ_WDATA_IN[31:2] == 30'h0) & (OBJ_WDATA_IN[1:0] != 2'h3);
    wire loading = (state_reg == ST_LOAD);
    wire bus_we = OBJ_WR_IN & hit_param & val_ok & !loading;
    wire cmd_refused = (hit_save | hit_cfg) & !cmd_ok;
    wire wr_bad = OBJ_WR_IN & (!(hit_param | hit_save | hit_cfg) | (hit_param & !val_ok) |
                  cmd_refused | (hit_param & loading));
    wire rd_bad = OBJ_RD_IN & !(hit_param | hit_save | hit_cfg | hit_stat);

    // ------------------------------------------------
    // maintenance commands
    // ------------------------------------------------
    maint_cmd_cell save_cell
    (
        .clk_in(REF_CLK_IN),
        .reset_in(RESET_IN),
        .wr_in(OBJ_WR_IN & hit_save & cmd_ok),
        .data_in(OBJ_WDATA_IN),
        .data_out(save_data),
        .exec_out(save_exec)
    );

    maint_cmd_cell cfg_cell
    (
        .clk_in(REF_CLK_IN),
        .reset_in(RESET_IN),
        .wr_in(OBJ_WR_IN & hit_cfg & cmd_ok),
        .data_in(OBJ_WDATA_IN),
        .data_out(cfg_data),
        .exec_out(cfg_exec)
    );

    // ------------------------------------------------
    // range validity and coordinate geometry
    // ------------------------------------------------
    wire [31:0] range_w = work_reg[wrap_pkg::W_RANGE];
    wire [31:0] gear_a = work_reg[wrap_pkg::W_GEAR_A];
    wire [31:0] turns = small_frame_reg ? wrap_pkg::TURNS_SMALL : wrap_pkg::TURNS_LARGE;
    wire cond1 = (range_w != 32'h0) && ((turns % range_w) == 32'h0);
    wire [63:0] num = 64'(range_w) * 64'(work_reg[wrap_pkg::W_GEAR_B]) * wrap_pkg::STEP_FACTOR;
    wire [63:0] steps64 = (gear_a == 32'h0) ? 64'h0 : num / 64'(gear_a);
    wire cond2 = (gear_a != 32'h0) && ((num % 64'(gear_a)) == 64'h0) &&
                 (steps64[63:31] == 33'h0) && (steps64 != 64'h0);
    wire [63:0] ratio_off = (steps64 * 64'(work_reg[wrap_pkg::W_RATIO])) / wrap_pkg::RATIO_FULL;
    wire signed [63:0] low64 = $signed(64'(signed'(work_reg[wrap_pkg::W_OFFS]))) -
                               $signed(ratio_off);
    wire signed [63:0] top64 = low64 + $signed(steps64);
    wire home_ok = (low64 <= 64'sh0) && (top64 > 64'sh0);
    wire wrap_on = (work_reg[wrap_pkg::W_EN] == wrap_pkg::DEF_EN);
    wire err_info_next = wrap_on & !(cond1 & cond2 & home_ok);
    wire [31:0] spacing = steps64[31:0] / work_reg[wrap_pkg::W_DIV];

    // ------------------------------------------------
    // control sequence
    // ------------------------------------------------
    wire nv_sig_ok = (nv_mem[wrap_pkg::W_MARK][31:16] == wrap_pkg::NV_SIG);
    wire nv_dirty = nv_mem[wrap_pkg::W_MARK][0];
    wire load_we = loading & nv_sig_ok & !nv_dirty;
    wire last_idx = (idx_reg == 3'(wrap_pkg::NV_PARAMS - 1));
    wire hold_done = (hold_reg >= NV_HOLD_CYCLES - 32'h1);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_LOAD: state_next = (last_idx | !nv_sig_ok | nv_dirty) ? ST_APPLY : ST_LOAD;
            ST_APPLY: state_next = ST_IDLE;
            ST_IDLE:
            begin
                if (save_exec)
                    state_next = ST_MARK;
                else if (cfg_exec)
                    state_next = ST_APPLY;
            end
            ST_MARK: state_next = ST_SAVE;
            ST_SAVE: state_next = last_idx ? ST_HOLD : ST_SAVE;
            ST_HOLD: state_next = hold_done ? ST_CLEAN : ST_HOLD;
            ST_CLEAN: state_next = ST_IDLE;
            ST_HALT: state_next = ST_HALT;
            default: state_next = ST_IDLE;
        endcase
        if (pfail_reg)
            state_next = ST_HALT;
    end

    wire nv_we = (state_reg == ST_MARK) | (state_reg == ST_SAVE) | (state_reg == ST_CLEAN);
    wire [2:0] nv_addr = (state_reg == ST_SAVE) ? idx_reg : wrap_pkg::W_MARK;
    wire [31:0] nv_wdata = (state_reg == ST_SAVE) ? work_reg[idx_reg] :
                           {wrap_pkg::NV_SIG, 15'h0, (state_reg == ST_MARK)};

    // non-volatile image survives resets
    always_ff @(posedge REF_CLK_IN)
    begin
        if (nv_we & !pfail_reg)
            nv_mem[nv_addr] <= nv_wdata;
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RESET_IN)
        begin
            state_reg <= ST_LOAD;
            idx_reg <= 3'h0;
            hold_reg <= 32'h0;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg <= ((state_reg == ST_LOAD) | (state_reg == ST_SAVE)) ? idx_reg + 3'h1 : 3'h0;
            hold_reg <= (state_reg == ST_HOLD) ? hold_reg + 32'h1 : 32'h0;
        end
    end

    // working memory: bus writes, or the power-up load
    always_ff @(posedge REF_CLK_IN)
    begin
        for (int i = 0; i < wrap_pkg::NV_PARAMS; i++)
        begin
            if (RESET_IN)
                work_reg[i] <= wrap_pkg::default_word(i);
            else if (load_we && (idx_reg == 3'(i)))
                work_reg[i] <= nv_mem[i];
            else if (bus_we && (obj_word == 3'(i)))
                work_reg[i] <= OBJ_WDATA_IN;
        end
    end

    // ------------------------------------------------
    // applied coordinate, position and marker
    // ------------------------------------------------
    logic err_info_reg;
    logic wrap_alarm_reg;
    logic mem_alarm_reg;
    logic app_on_reg;
    logic signed [31:0] app_low_reg;
    logic signed [31:0] app_high_reg;
    logic [31:0] app_spacing_reg;
    logic signed [31:0] pos_reg;
    logic signed [31:0] pos_next;
    logic marker_reg;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;

    wire applying = (state_reg == ST_APPLY);
    wire wrapping = app_on_reg;
    wire signed [31:0] pos_up = (wrapping && pos_reg == app_high_reg) ? app_low_reg :
                                pos_reg + 32'sh1;
    wire signed [31:0] pos_dn = (wrapping && pos_reg == app_low_reg) ? app_high_reg :
                                pos_reg - 32'sh1;
    assign pos_next = !STEP_IN ? pos_reg : DIR_IN ? pos_up : pos_dn;
    wire [31:0] pos_mag = pos_next[31] ? 32'(-pos_next) : 32'(pos_next);
    wire on_boundary = (app_spacing_reg != 32'h0) && ((pos_mag % app_spacing_reg) == 32'h0);
    wire marker_next = wrapping & on_boundary;

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RESET_IN)
        begin
            err_info_reg <= 1'b0;
            wrap_alarm_reg <= 1'b0;
            mem_alarm_reg <= 1'b0;
            app_on_reg <= 1'b0;
            app_low_reg <= 32'sh0;
            app_high_reg <= 32'sh0;
            app_spacing_reg <= 32'h0;
            pos_reg <= 32'sh0;
            marker_reg <= 1'b0;
        end
        else
        begin
            err_info_reg <= err_info_next;
            if (applying & err_info_next)
                wrap_alarm_reg <= 1'b1;
            if (loading & nv_sig_ok & nv_dirty)
                mem_alarm_reg <= 1'b1;
            if (applying)
            begin
                app_on_reg <= wrap_on & !err_info_next;
                app_low_reg <= low64[31:0];
                app_high_reg <= 32'(top64 - 64'sh1);
                app_spacing_reg <= spacing;
            end
            pos_reg <= pos_next;
            marker_reg <= marker_next;
        end
    end

    // ------------------------------------------------
    // object read and answer
    // ------------------------------------------------
    wire [31:0] status_word = {28'h0, NV_BUSY_OUT, mem_alarm_reg, wrap_alarm_reg, err_info_reg};
    assign rdata_next = hit_param ? work_reg[obj_word] :
                        hit_save ? {30'h0, save_data} :
                        hit_cfg ? {30'h0, cfg_data} :
                        hit_stat ? status_word : 32'h0;

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RESET_IN)
        begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            ack_reg <= OBJ_WR_IN | OBJ_RD_IN;
            err_reg <= wr_bad | rd_bad;
            if (OBJ_RD_IN)
                rdata_reg <= rdata_next;
        end
    end

    assign OBJ_ACK_OUT = ack_reg;
    assign OBJ_ERR_OUT = err_reg;
    assign OBJ_RDATA_OUT = rdata_reg;
    assign WRAP_POS_OUT = pos_reg;
    assign WRAP_DIVISION_MARKER_OUT = marker_reg;
    assign WRAP_ERR_INFO_OUT = err_info_reg;
    assign ALARM_OUT = wrap_alarm_reg | mem_alarm_reg;
    assign ALARM_CODE_OUT = mem_alarm_reg ? wrap_pkg::ALM_MEM :
                            wrap_alarm_reg ? wrap_pkg::ALM_WRAP : wrap_pkg::ALM_NONE;
    assign NV_BUSY_OUT = nv_we | (state_reg == ST_HOLD);

endmodule

// >>> tb/wrap_coord_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module wrap_coord_monitor
#(
    parameter logic [31:0] NV_HOLD_CYCLES = 32'h14
)
(
    // watched ports
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    input wire logic OBJ_WR_IN,
    input wire logic OBJ_RD_IN,
    input wire logic [15:0] OBJ_INDEX_IN,
    input wire logic [31:0] OBJ_WDATA_IN,
    input wire logic OBJ_ACK_OUT,
    input wire logic OBJ_ERR_OUT,
    input wire logic STEP_IN,
    input wire logic DIR_IN,
    input wire logic POWER_FAIL_IN,
    input wire logic [31:0] WRAP_POS_OUT,
    input wire logic ALARM_OUT,
    input wire logic [7:0] ALARM_CODE_OUT,
    input wire logic NV_BUSY_OUT
);
    logic [31:0] busy_cnt;
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RESET_IN || POWER_FAIL_IN);
    // length of the current save sequence
    always_ff @(posedge REF_CLK_IN)
        if (RESET_IN || !NV_BUSY_OUT)
            busy_cnt <= 32'h0;
        else
            busy_cnt <= busy_cnt + 32'h1;
    property p_ack;
        (OBJ_WR_IN || OBJ_RD_IN) |=> OBJ_ACK_OUT;
    endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge");
    property p_pos_hold;
        !STEP_IN |=> $stable(WRAP_POS_OUT);
    endproperty
    a_pos_hold: assert property (p_pos_hold) else $error("position moved without step");
    property p_pos_up;
        STEP_IN && DIR_IN |=> ($signed(WRAP_POS_OUT) == $signed($past(WRAP_POS_OUT)) + 1)
            || ($signed(WRAP_POS_OUT) < $signed($past(WRAP_POS_OUT)));
    endproperty
    a_pos_up: assert property (p_pos_up) else $error("bad forward step");
    property p_alarm_hold;
        ALARM_OUT |=> ALARM_OUT;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");
    property p_alarm_code;
        ALARM_OUT == (ALARM_CODE_OUT != 8'h00);
    endproperty
    a_alarm_code: assert property (p_alarm_code) else $error("alarm code disagrees");
    property p_busy_len;
        $fell(NV_BUSY_OUT) |-> busy_cnt >= NV_HOLD_CYCLES + 32'h7;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("save hold too short");
    property p_ratio;
        OBJ_WR_IN && OBJ_INDEX_IN == 16'h41cb && OBJ_WDATA_IN > 32'h2710 |=> OBJ_ERR_OUT;
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio above range accepted");
    property p_div;
        OBJ_WR_IN && OBJ_INDEX_IN == 16'h41cd
            && (OBJ_WDATA_IN == 32'h0 || OBJ_WDATA_IN > 32'h1fffffff) |=> OBJ_ERR_OUT;
    endproperty
    a_div: assert property (p_div) else $error("bad division count accepted");
endmodule
bind wrap_coord_top wrap_coord_monitor #(.NV_HOLD_CYCLES(NV_HOLD_CYCLES)) wrap_coord_monitor_inst
(
    .REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .OBJ_WR_IN(OBJ_WR_IN), .OBJ_RD_IN(OBJ_RD_IN),
    .OBJ_INDEX_IN(OBJ_INDEX_IN), .OBJ_WDATA_IN(OBJ_WDATA_IN), .OBJ_ACK_OUT(OBJ_ACK_OUT),
    .OBJ_ERR_OUT(OBJ_ERR_OUT), .STEP_IN(STEP_IN), .DIR_IN(DIR_IN), .POWER_FAIL_IN(POWER_FAIL_IN),
    .WRAP_POS_OUT(WRAP_POS_OUT), .ALARM_OUT(ALARM_OUT), .ALARM_CODE_OUT(ALARM_CODE_OUT),
    .NV_BUSY_OUT(NV_BUSY_OUT)
);

// >>> tb/fieldbus_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// object bus master
// ----------------------------------------
module fieldbus_master_model
(
    // answer side
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic err_in,
    input wire logic [31:0] rdata_in,
    // request side
    output logic wr_out,
    output logic rd_out,
    output logic [15:0] index_out,
    output logic [7:0] sub_out,
    output logic [31:0] wdata_out
);
    initial
    begin
        {wr_out, rd_out, index_out, sub_out, wdata_out} = 58'h0;
    end
    task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, output logic ok, output logic e, output logic [31:0] q);
        @(negedge clk_in);
        {wr_out, rd_out, index_out, sub_out, wdata_out} = {w, !w, i, s, d};
        @(negedge clk_in);
        ok = (ack_in === 1'b1);
        e = err_in;
        q = rdata_in;
        // strobes drop, the other lines show the inverse
        {wr_out, rd_out, index_out, sub_out, wdata_out} = {2'h0, ~i, ~s, ~d};
    endtask
endmodule

// >>> tb/wrap_coordinate_and_param_save_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module wrap_coordinate_and_param_save_bench;
    logic clk, rst, step_r, dir_r, small_r, pf_r;
    logic wr, rd, ack, err, mark, erri, alarm, busy;
    logic [15:0] idx;
    logic [7:0] sub, code;
    logic [31:0] wdata, rdata, pos;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    wrap_coord_top #(.NV_HOLD_CYCLES(32'h14)) wrap_coord_top_inst
    (
        .REF_CLK_IN(clk), .RESET_IN(rst), .OBJ_WR_IN(wr), .OBJ_RD_IN(rd), .OBJ_INDEX_IN(idx),
        .OBJ_SUB_IN(sub), .OBJ_WDATA_IN(wdata), .OBJ_RDATA_OUT(rdata), .OBJ_ACK_OUT(ack),
        .OBJ_ERR_OUT(err), .STEP_IN(step_r), .DIR_IN(dir_r), .SMALL_FRAME_IN(small_r),
        .POWER_FAIL_IN(pf_r), .WRAP_POS_OUT(pos), .WRAP_DIVISION_MARKER_OUT(mark),
        .WRAP_ERR_INFO_OUT(erri), .ALARM_OUT(alarm), .ALARM_CODE_OUT(code), .NV_BUSY_OUT(busy)
    );
    fieldbus_master_model fieldbus_master_model_inst
    (
        .clk_in(clk), .ack_in(ack), .err_in(err), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
        .index_out(idx), .sub_out(sub), .wdata_out(wdata)
    );
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic flag(input string what, input logic seen, input logic exp);
        check(what, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic obj(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, input logic ee, input logic [31:0] eq);
        logic ok, e;
        logic [31:0] q;
        fieldbus_master_model_inst.xfer(w, i, s, d, ok, e, q);
        flag("ack", ok, 1'b1);
        flag("err", e, ee);
        if (!w && !ee)
            check("rdata", q, eq);
    endtask
    task automatic wr_obj(input logic [15:0] i, input logic [31:0] d, input logic ee);
        obj(1'b1, i, 8'h00, d, ee, 32'h0);
    endtask
    task automatic rd_obj(input logic [15:0] i, input logic [31:0] eq);
        obj(1'b0, i, 8'h00, 32'h0, 1'b0, eq);
    endtask
    task automatic err_is(input logic exp);
        tick(2);
        flag("err_info", erri, exp);
    endtask
    task automatic wait_busy(input logic lvl);
        for (int k = 0; k < 100 && busy !== lvl; k++)
            tick(1);
        flag("nv_busy", busy, lvl);
    endtask
    task automatic step(input logic d, input int n);
        {step_r, dir_r} = {1'b1, d};
        tick(n);
        step_r = 1'b0;
        tick(1);
    endtask
    task automatic do_reset();
        {rst, pf_r} = 2'h2;
        tick(16);
        rst = 1'b0;
        tick(12);
    endtask
    task automatic t_defaults();
        logic [15:0] ix [5] = '{16'h41c7, 16'h41c9, 16'h41cb, 16'h41cc, 16'h41cd};
        logic [31:0] dv [5] = '{32'h1, 32'ha, 32'h1388, 32'h0, 32'h1};
        for (int k = 0; k < 5; k++)
            rd_obj(ix[k], dv[k]);
        flag("err_info", erri, 1'b0);
        flag("marker", mark, 1'b1);
    endtask
    task automatic t_refuse();
        wr_obj(16'h41cb, 32'h2710, 1'b0);
        wr_obj(16'h41cb, 32'h2711, 1'b1);
        rd_obj(16'h41cb, 32'h2710);
        wr_obj(16'h41cd, 32'h1fffffff, 1'b0);
        wr_obj(16'h41cd, 32'h20000000, 1'b1);
        wr_obj(16'h41cd, 32'h0, 1'b1);
        rd_obj(16'h41cd, 32'h1fffffff);
        wr_obj(16'h40c9, 32'h3, 1'b1);
        obj(1'b0, 16'h1000, 8'h00, 32'h0, 1'b1, 32'h0);
        wr_obj(16'h41cb, 32'h1388, 1'b0);
    endtask
    task automatic t_marker();
        wr_obj(16'h41c9, 32'h5, 1'b0);
        wr_obj(16'h41cd, 32'h4, 1'b0);
        wr_obj(16'h40c6, 32'h1, 1'b0);
        tick(3);
        flag("marker", mark, 1'b1);
        step(1'b0, 2500);
        check("pos", pos, 32'hfffff63c);
        flag("marker", mark, 1'b1);
        step(1'b0, 1);
        check("pos", pos, 32'h000009c3);
        flag("marker", mark, 1'b0);
        step(1'b1, 1);
        check("pos", pos, 32'hfffff63c);
        wr_obj(16'h41c7, 32'h0, 1'b0);
        wr_obj(16'h40c6, 32'h2, 1'b0);
        tick(3);
        flag("marker", mark, 1'b0);
        rd_obj(16'h40c6, 32'h1);
    endtask
    task automatic t_valid();
        wr_obj(16'h41c9, 32'h2710, 1'b0);
        wr_obj(16'h41c7, 32'h1, 1'b0);
        err_is(1'b1);
        wr_obj(16'h41c7, 32'h0, 1'b0);
        err_is(1'b0);
        wr_obj(16'h41c7, 32'h1, 1'b0);
        wr_obj(16'h41c9, 32'h90, 1'b0);
        obj(1'b1, 16'h6091, 8'h01, 32'h3, 1'b0, 32'h0);
        err_is(1'b0);
        wr_obj(16'h41c9, 32'ha, 1'b0);
        err_is(1'b1);
        wr_obj(16'h41c9, 32'h4650, 1'b0);
        obj(1'b1, 16'h6091, 8'h01, 32'h1, 1'b0, 32'h0);
        err_is(1'b0);
        small_r = 1'b1;
        tick(4);
        err_is(1'b1);
        small_r = 1'b0;
        tick(4);
        wr_obj(16'h41cc, 32'h00895441, 1'b0);
        err_is(1'b1);
        wr_obj(16'h40c6, 32'h2, 1'b0);
        tick(3);
        flag("alarm", alarm, 1'b1);
        check("alarm_code", {24'h0, code}, 32'h2f);
        wr_obj(16'h41cc, 32'h0, 1'b0);
        err_is(1'b0);
    endtask
    task automatic t_cmds();
        do_reset();
        wr_obj(16'h41c9, 32'h5, 1'b0);
        wr_obj(16'h40c9, 32'h1, 1'b0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        wr_obj(16'h40c9, 32'h1, 1'b0);
        tick(6);
        flag("nv_busy", busy, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            wr_obj(16'h40c9, 32'h2, 1'b0);
            wait_busy(1'b1);
            wait_busy(1'b0);
        end
        rd_obj(16'h40c9, 32'h1);
        wr_obj(16'h41c9, 32'h14, 1'b0);
        do_reset();
        rd_obj(16'h41c9, 32'h5);
    endtask
    task automatic t_powerfail();
        wr_obj(16'h41c9, 32'h14, 1'b0);
        wr_obj(16'h40c9, 32'h2, 1'b0);
        wait_busy(1'b1);
        pf_r = 1'b1;
        tick(8);
        do_reset();
        flag("alarm", alarm, 1'b1);
        check("alarm_code", {24'h0, code}, 32'h41);
        rd_obj(16'h40f0, 32'h4);
        rd_obj(16'h41c9, 32'ha);
    endtask
    initial
    begin
        {step_r, dir_r, small_r} = 3'h0;
        do_reset();
        t_defaults();
        t_refuse();
        t_marker();
        t_valid();
        t_cmds();
        t_powerfail();
        stop_test();
    end
endmodule
